// *** common/nco_host_pkg.sv ***
// Shared widths, destination addresses and pin bundles for the oscillator host port.
`default_nettype none
package nco_host_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int TUNING_W = 32;

  // Destination register addresses on the host address lines.
  localparam logic [2:0] ADDR_WORD_A_LO = 3'h0;
  localparam logic [2:0] ADDR_WORD_A_HI = 3'h1;
  localparam logic [2:0] ADDR_WORD_B_LO = 3'h2;
  localparam logic [2:0] ADDR_WORD_B_HI = 3'h3;

  // Destination address of each 16-bit half, indexed a low, a high, b low, b high.
  localparam logic [3:0][2:0] HALF_ADDR = {ADDR_WORD_B_HI, ADDR_WORD_B_LO, ADDR_WORD_A_HI,
                                           ADDR_WORD_A_LO};

  // Reset values.
  localparam logic [31:0] TUNING_RESET = 32'h0000_0000;
  localparam logic [31:0] PHASE_RESET = 32'h0000_0000;

  // Host pins as seen at the device boundary.
  typedef struct packed {
    logic tuning_register_choice;
    logic write_n;
    logic [2:0] host_address_lines;
    logic [15:0] host_data_bus;
  } host_pins_type;

  // Pin levels assumed while in reset: the strobe idles high so no false rise follows release.
  localparam host_pins_type PINS_RESET = '{
    tuning_register_choice: 1'b0,
    write_n: 1'b1,
    host_address_lines: 3'h0,
    host_data_bus: 16'h0000
  };

  // Captured write awaiting transfer into its destination.
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] data;
  } held_write_type;

  typedef enum logic [0:0] {
    HOLD_IDLE = 1'b0,
    HOLD_PENDING = 1'b1
  } hold_state_type;

endpackage
`default_nettype wire

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for a bundle of asynchronous pins.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // The first stage may go metastable; only the second stage reads it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= RESET_VALUE;
      stage2_ff <= RESET_VALUE;
    end else begin
      stage1_ff <= d;
      stage2_ff <= stage1_ff;
    end
  end

  assign q = stage2_ff;

endmodule
`default_nettype wire

// *** verilog/nco_host_port.sv ***
// Host write capture, tuning word registers and phase accumulator of the oscillator.
`default_nettype none
// Function
// R1: Output frequency is the selected tuning word as a binary fraction of clk.
// R2: Tuning choice input picks which of two tuning words feeds the accumulator.
// R3: Tuning choice is sampled only on clk rising edges; switches start there.
// R4: A choice change at a clk edge may take effect then or one cycle later; the code first uses it two or three edges later.
// R5: Host keeps tuning choice stable around clk rising edges.
// R6: Host data is captured into a holding stage on the write strobe rise.
// R7: Held data moves to its destination on a later clk edge, not the strobe.
// R8: A strobe rise at a clk edge may load then or one cycle later; the code loads it three or four edges later.
// R9: A strobe rise after a clk edge loads on a following clk edge.
// R10: Host places strobe rise clearly before a clk edge.
// R11: Each write carries 16 data bits and 3 address bits choosing the destination.
// R12: Two 32-bit tuning words; first used when choice low, second when high.
// R13: Address is held with data until transfer, so new strobes cannot corrupt it.
module nco_host_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] host_data_bus,
  input wire logic [2:0] host_address_lines,
  input wire logic write_n,
  input wire logic tuning_register_choice,
  output logic [31:0] phase_out,
  output logic [31:0] tuning_word_a,
  output logic [31:0] tuning_word_b,
  output logic choice_sampled
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  nco_host_pkg::host_pins_type pins_raw;
  nco_host_pkg::host_pins_type pins_s;

  assign pins_raw.tuning_register_choice = tuning_register_choice;
  assign pins_raw.write_n = write_n;
  assign pins_raw.host_address_lines = host_address_lines;
  assign pins_raw.host_data_bus = host_data_bus;

  // Data, address and strobe share one synchroniser so they stay aligned to the same sample.
  // A strobe rise right at a clk edge is seen at that edge or the next one.
  pin_sync #(
    .WIDTH($bits(nco_host_pkg::host_pins_type)),
    .RESET_VALUE(nco_host_pkg::PINS_RESET)
  ) u_pin_sync ( // R8
    .clk(clk),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe edge detection and holding stage.

  logic write_n_prev_ff;
  logic strobe_rise;
  nco_host_pkg::hold_state_type hold_state_ff;
  nco_host_pkg::hold_state_type nxt_hold_state;
  nco_host_pkg::held_write_type held_ff;
  nco_host_pkg::held_write_type nxt_held;
  logic transfer;

  // The strobe idles high, so reset assumes high to avoid a false edge after release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_n_prev_ff <= nco_host_pkg::PINS_RESET.write_n;
    end else begin
      write_n_prev_ff <= pins_s.write_n;
    end
  end

  assign strobe_rise = pins_s.write_n & ~write_n_prev_ff; // R6 R8
  assign transfer = (hold_state_ff == nco_host_pkg::HOLD_PENDING); // R7 R9

  // A strobe in the transfer cycle is still caught: the old word leaves as the new one enters.
  assign nxt_held = strobe_rise ?
    '{addr: pins_s.host_address_lines, data: pins_s.host_data_bus} : held_ff; // R6 R11 R13

  always_comb begin
    case (hold_state_ff)
      nco_host_pkg::HOLD_IDLE: begin
        if (strobe_rise) begin
          nxt_hold_state = nco_host_pkg::HOLD_PENDING;
        end else begin
          nxt_hold_state = nco_host_pkg::HOLD_IDLE;
        end
      end
      nco_host_pkg::HOLD_PENDING: begin
        // The pending word leaves this cycle; a fresh strobe keeps the stage busy.
        if (strobe_rise) begin
          nxt_hold_state = nco_host_pkg::HOLD_PENDING;
        end else begin
          nxt_hold_state = nco_host_pkg::HOLD_IDLE;
        end
      end
      default: begin
        nxt_hold_state = nco_host_pkg::HOLD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_state_ff <= nco_host_pkg::HOLD_IDLE;
    end else begin
      hold_state_ff <= nxt_hold_state; // R7
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held_ff <= '0;
    end else begin
      held_ff <= nxt_held; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Destination tuning words.

  logic [3:0][15:0] half_q;
  logic [3:0] half_hit;
  logic [31:0] word_a_ff;
  logic [31:0] word_b_ff;

  // Each destination address owns one 16-bit half, and the halves load independently.
  // Addresses 4 to 7 fall outside this block and match no half.
  for (genvar h = 0; h < 4; h++) begin : g_half
    logic [15:0] half_ff;
    logic [15:0] nxt_half;

    assign half_hit[h] = transfer && (held_ff.addr == nco_host_pkg::HALF_ADDR[h]); // R11

    // A 32-bit word written as two halves runs for a while with a mixed value.
    assign nxt_half = half_hit[h] ? held_ff.data : half_ff; // R7 R12

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        half_ff <= nco_host_pkg::TUNING_RESET[16 * (h % 2) +: 16];
      end else begin
        half_ff <= nxt_half; // R7
      end
    end

    assign half_q[h] = half_ff;
  end

  // The halves are flip-flops, so the assembled words are register outputs as well.
  assign word_a_ff = {half_q[1], half_q[0]}; // R12
  assign word_b_ff = {half_q[3], half_q[2]}; // R12

  ////////////////////////////////////////////////////////////////////////////////
  // Phase accumulator.

  logic [31:0] phase_ff;
  logic [31:0] selected_word;
  logic [31:0] nxt_phase;

  // The choice is taken from the synchroniser, so it changes only on clk edges.
  assign selected_word = pins_s.tuning_register_choice ? word_b_ff : word_a_ff; // R2 R3 R4 R12
  // Wrapping 32-bit add: output frequency is selected_word / 2^32 of clk.
  assign nxt_phase = phase_ff + selected_word; // R1

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= nco_host_pkg::PHASE_RESET;
    end else begin
      phase_ff <= nxt_phase; // R1
    end
  end

  assign phase_out = phase_ff;
  assign tuning_word_a = word_a_ff;
  assign tuning_word_b = word_b_ff;
  assign choice_sampled = pins_s.tuning_register_choice;

endmodule
`default_nettype wire

// *** test/nco_host_port_props.sv ***
// Port checker for the oscillator host port.
`default_nettype none
module nco_host_port_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] host_data_bus,
  input wire logic [2:0] host_address_lines,
  input wire logic write_n,
  input wire logic tuning_register_choice,
  input wire logic [31:0] phase_out,
  input wire logic [31:0] tuning_word_a,
  input wire logic [31:0] tuning_word_b,
  input wire logic choice_sampled
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_acc_add: assert property (
    phase_out == $past(phase_out) + ($past(choice_sampled) ?
    $past(tuning_word_b) : $past(tuning_word_a))) else $error("phase step");
  chk_choice_lag: assert property (
    choice_sampled == $past(tuning_register_choice, 2)) else $error("choice lag");
  chk_a_cause: assert property (
    $changed(tuning_word_a) |-> $past(write_n, 4) && !$past(write_n, 5)) else $error("a moved");
  chk_b_cause: assert property (
    $changed(tuning_word_b) |-> $past(write_n, 4) && !$past(write_n, 5)) else $error("b moved");
  chk_a_low: assert property (
    $rose(write_n) && host_address_lines == 3'h0 |->
    ##4 tuning_word_a[15:0] == $past(host_data_bus, 4)) else $error("a low");
  chk_a_high: assert property (
    $rose(write_n) && host_address_lines == 3'h1 |->
    ##4 tuning_word_a[31:16] == $past(host_data_bus, 4)) else $error("a high");
  chk_b_low: assert property (
    $rose(write_n) && host_address_lines == 3'h2 |->
    ##4 tuning_word_b[15:0] == $past(host_data_bus, 4)) else $error("b low");
  chk_b_high: assert property (
    $rose(write_n) && host_address_lines == 3'h3 |->
    ##4 tuning_word_b[31:16] == $past(host_data_bus, 4)) else $error("b high");
  chk_bad_addr: assert property (
    $rose(write_n) && host_address_lines[2] |->
    ##4 ($stable(tuning_word_a) && $stable(tuning_word_b))) else $error("bad addr");
endmodule
`default_nettype wire

// *** test/host_cpu_model.sv ***
// Host processor model driving the write and choice pins.
`default_nettype none
module host_cpu_model (
  input wire logic clk,
  output var nco_host_pkg::host_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '{1'b0, 1'b1, 3'h0, 16'h0000};
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    pins.host_address_lines = a;
    pins.host_data_bus = d;
    pins.write_n = 1'b0;
    repeat (2) @(negedge clk);
    pins.write_n = 1'b1;
    // Inverted lines after the strobe expose any late sampling.
    @(negedge clk);
    pins.host_address_lines = ~a;
    pins.host_data_bus = ~d;
    @(negedge clk);
  endtask
  task automatic choose(input logic c);
    @(negedge clk);
    pins.tuning_register_choice = c;
  endtask
endmodule
`default_nettype wire

// *** test/nco_host_port_test.sv ***
// Testbench for the oscillator host port.
`default_nettype none
module nco_host_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic nrst;
  nco_host_pkg::host_pins_type pins;
  logic [31:0] phase_out, tuning_word_a, tuning_word_b, p0;
  logic choice_sampled;
  int n_fail = 0;
  int total_checks = 0;
  host_cpu_model u_host_cpu_model (.clk, .pins);
  nco_host_port u_nco_host_port (.clk, .nrst, .host_data_bus(pins.host_data_bus),
    .host_address_lines(pins.host_address_lines), .write_n(pins.write_n),
    .tuning_register_choice(pins.tuning_register_choice), .phase_out, .tuning_word_a,
    .tuning_word_b, .choice_sampled);
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk(phase_out === 32'h0 && tuning_word_a === 32'h0 && tuning_word_b === 32'h0, "reset");
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    $display("reset test done");
  endtask
  task automatic t_writes();
    u_host_cpu_model.wr(3'h0, 16'h89ab);
    @(posedge clk);
    #1 chk(tuning_word_a === 32'h0, "early load");
    @(posedge clk);
    #1 chk(tuning_word_a === 32'h0000_89ab, "late load");
    u_host_cpu_model.wr(3'h1, 16'h0123);
    u_host_cpu_model.wr(3'h2, 16'h4567);
    u_host_cpu_model.wr(3'h3, 16'hcdef);
    u_host_cpu_model.wr(3'h5, 16'hffff);
    repeat (4) @(negedge clk);
    chk(tuning_word_a === 32'h0123_89ab, "word a");
    chk(tuning_word_b === 32'hcdef_4567, "word b");
    $display("write test done");
  endtask
  task automatic t_choice(input logic c, input logic [31:0] w);
    u_host_cpu_model.choose(c);
    repeat (3) @(negedge clk);
    chk(choice_sampled === c, "choice");
    p0 = phase_out;
    repeat (8) @(negedge clk);
    chk(phase_out === p0 + (w << 3), "phase step");
    $display("choice test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    do_reset();
    t_writes();
    t_choice(1'b1, 32'hcdef_4567);
    t_choice(1'b0, 32'h0123_89ab);
    do_reset();
    give_verdict();
  end
endmodule
bind nco_host_port nco_host_port_props u_props (.clk, .nrst, .host_data_bus,
  .host_address_lines, .write_n, .tuning_register_choice, .phase_out, .tuning_word_a,
  .tuning_word_b, .choice_sampled);
`default_nettype wire
